// ### dcls_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module dcls_checker (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [15:0] I_TARGET,
    input wire logic [15:0] V_TARGET,
    input wire logic ZERO_CURRENT,
    input wire logic ERROR_STOP,
    input wire logic EMERG_STOP
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // A completed write may clear a latched stop
    wire logic wr_done = PSEL && PENABLE && PREADY && PWRITE;
    // Bus phases
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_access; PSEL && PENABLE; endsequence
    property p_ready_lat; s_setup ##1 s_access |-> ##1 PREADY; endproperty
    a_ready_lat: assert property (p_ready_lat) else $error("ready late");
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_err_data; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("error without zero data");
    property p_zc_target; ZERO_CURRENT |-> I_TARGET == 16'h0; endproperty
    a_zc_target: assert property (p_zc_target) else $error("current in zero mode");
    property p_stop_zc; ERROR_STOP || EMERG_STOP |-> ##[0:3] ZERO_CURRENT && V_TARGET == 16'h0;
    endproperty
    a_stop_zc: assert property (p_stop_zc) else $error("stop kept output");
    property p_err_hold; ERROR_STOP && !wr_done |=> ERROR_STOP; endproperty
    a_err_hold: assert property (p_err_hold) else $error("error stop dropped");
    property p_em_hold; EMERG_STOP && !wr_done |=> EMERG_STOP; endproperty
    a_em_hold: assert property (p_em_hold) else $error("emergency dropped");
    property p_stop_rise; $rose(ERROR_STOP) |-> ##2 ZERO_CURRENT; endproperty
    a_stop_rise: assert property (p_stop_rise) else $error("stop kept current");
endmodule : dcls_checker
bind dcls_top dcls_checker u_chk (.REF_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PRDATA,
    .PREADY, .PSLVERR, .I_TARGET, .V_TARGET, .ZERO_CURRENT, .ERROR_STOP, .EMERG_STOP);
`default_nettype wire

// ### dcls_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Far side measurement source
// ----
module dcls_far_end (
    input wire logic clk,
    output logic [15:0] meas_v = 16'h0,
    output logic [15:0] meas_i = 16'h0,
    output logic meas_valid = 1'b0
);
    // No shutdown path on reduced current or battery loss
    // Data held past capture, then scrambled
    task automatic send(input logic [15:0] v, input logic [15:0] i);
        @(posedge clk);
        meas_v <= v;
        meas_i <= i;
        @(posedge clk);
        meas_valid <= 1'b1;
        repeat (5) @(posedge clk);
        meas_valid <= 1'b0;
        meas_v <= ~v;
        meas_i <= ~i;
    endtask : send
endmodule : dcls_far_end
`default_nettype wire

// ### dcls_pkg.sv
`default_nettype none
package dcls_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000; // REF_CLK rate
    localparam int MS_PER_S = 1000; // Millisecond scale
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S; // Cycles in one millisecond
    localparam int OV_PERSIST_MS = 400; // Overvoltage persistence
    localparam int UV_PERSIST_MS = 3000; // Undervoltage persistence, 3 s
    localparam int MINP_PERSIST_MS = 3000; // Low power persistence, 3 s
    localparam int OC_PERSIST_MS = 500; // Overcurrent persistence, 0.5 s
    localparam int MEAS_MAX_AGE_MS = 200; // Freshness of reported samples
    localparam int TMR_W = 12; // Millisecond timer width
    localparam logic [2:0] OC_NUM = 3'h6; // 120 percent as 6/5
    localparam logic [2:0] OC_DEN = 3'h5;
    localparam logic [2:0] UV_NUM = 3'h4; // 80 percent as 4/5
    localparam logic [2:0] UV_DEN = 3'h5;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_VEH_I_REQ = 8'h04;
    localparam logic [7:0] OFS_VEH_V_REQ = 8'h08;
    localparam logic [7:0] OFS_VEH_P_REQ = 8'h0C;
    localparam logic [7:0] OFS_VEH_I_MAX = 8'h10;
    localparam logic [7:0] OFS_VEH_V_MAX = 8'h14;
    localparam logic [7:0] OFS_VEH_P_MAX = 8'h18;
    localparam logic [7:0] OFS_STA_I_MIN = 8'h1C;
    localparam logic [7:0] OFS_STA_I_MAX = 8'h20;
    localparam logic [7:0] OFS_STA_V_MIN = 8'h24;
    localparam logic [7:0] OFS_STA_V_MAX = 8'h28;
    localparam logic [7:0] OFS_STA_P_MIN = 8'h2C;
    localparam logic [7:0] OFS_STA_P_MAX = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;
    localparam logic [7:0] OFS_MASK = 8'h38;
    localparam logic [7:0] OFS_TARGET = 8'h3C;
    localparam logic [7:0] OFS_MSG_CMD = 8'h40;
    localparam logic [7:0] OFS_MSG_V = 8'h44;
    localparam logic [7:0] OFS_MSG_I = 8'h48;
    localparam logic [7:0] OFS_MSG_IMAX = 8'h4C;
    localparam logic [7:0] OFS_MSG_PMAX = 8'h50;
    localparam logic [7:0] OFS_MSG_FLAGS = 8'h54;
    localparam logic [7:0] OFS_PLIMIT = 8'h58;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0; // Energy transfer enabled
    localparam int ST_OV = 0; // Overvoltage error stop
    localparam int ST_UV = 1; // Undervoltage error stop
    localparam int ST_OC = 2; // Emergency stop
    localparam int ST_ZC = 3; // Zero current mode entered
    localparam int ST_MSG = 4; // Message snapshot ready
    localparam int ST_W = 5;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : dcls_pkg
`default_nettype wire

// ### dcls_top.sv
// Summary of operation
// - Report power limit drop in next message
// - Request below station minimum: zero current
// - Clamp current to smaller maximum current
// - Overvoltage over 400 ms: error stop
// - Low voltage over 3 s: error stop
// - Clamp voltage target to station maximum
// - Above requested voltage: keep smaller voltage
// - Power request below minimum: zero current
// - Low V times I over 3 s
// - Cap power at smaller maximum power
// - Send samples within 200 ms or remeasure
// - Overcurrent or undervoltage 0.5 s: emergency
// - Zero current mode drives target zero
// - Unable to deliver: advertise zero current
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Persistence timer
// ----------------------------------------------------------------
module dcls_persist #(
    parameter int LIMIT_MS = 400
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic cond,
    output logic expired
);
    import dcls_pkg::*;
    logic [TMR_W-1:0] cnt_reg; // Milliseconds the condition has held
    initial begin
        if (LIMIT_MS < 1 || LIMIT_MS >= (1 << TMR_W) - 1) begin
            $error("dcls_persist: LIMIT_MS out of range");
        end
    end
    // Count whole ticks, saturating one past the limit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (!cond) begin
            cnt_reg <= '0;
        end else if (tick && cnt_reg <= TMR_W'(LIMIT_MS)) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
    // More than the limit has elapsed
    assign expired = cond && (cnt_reg > TMR_W'(LIMIT_MS));
endmodule : dcls_persist

// ----------------------------------------------------------------
// Charge limit supervisor top
// ----------------------------------------------------------------
module dcls_top import dcls_pkg::*; #(
    parameter int CYC_MS = CYC_PER_MS
) (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] MEAS_V,
    input wire logic [15:0] MEAS_I,
    input wire logic MEAS_VALID,
    output logic [15:0] I_TARGET,
    output logic [15:0] V_TARGET,
    output logic [31:0] P_LIMIT,
    output logic ZERO_CURRENT,
    output logic ERROR_STOP,
    output logic EMERG_STOP,
    output logic REMEASURE_REQ,
    output logic IRQ
);
    initial begin
        if (CYC_MS < 2) begin
            $error("dcls_top: CYC_MS must be at least 2");
        end
    end

    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg; // Release stages
    logic rst_n; // Synchronous copy used everywhere
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Data taken only on the valid edge
    logic [32:0] meas_s1_reg; // First stage, read only by second
    logic [32:0] meas_s2_reg; // Second stage
    logic valid_d_reg; // Edge detect of synced valid
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            meas_s1_reg <= '0;
            meas_s2_reg <= '0;
            valid_d_reg <= 1'b0;
        end else begin
            meas_s1_reg <= {MEAS_VALID, MEAS_V, MEAS_I};
            meas_s2_reg <= meas_s1_reg;
            valid_d_reg <= meas_s2_reg[32];
        end
    end
    logic meas_new;
    assign meas_new = meas_s2_reg[32] && !valid_d_reg;

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [15:0] div_reg; // Cycle divider
    logic tick_reg; // One pulse per millisecond
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == 16'(CYC_MS - 1));
            div_reg <= (div_reg == 16'(CYC_MS - 1)) ? 16'h0000 : div_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic [31:0] regs_reg [1:12]; // Request and limit words, 0x04..0x30
    logic run_reg; // Energy transfer enabled
    logic [ST_W-1:0] sts_reg; // Sticky events
    logic [ST_W-1:0] mask_reg; // Interrupt enables
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic acc; // Access completes this edge
    logic wr;
    logic mapped;
    logic [31:0] rd_mux;
    assign acc = PSEL && PENABLE && pready_reg;
    assign wr = acc && PWRITE && mapped;

    // Views of the written words
    logic [15:0] i_req, v_req, vehicle_max_current, vehicle_max_battery_voltage, i_min, i_max, v_min, v_max;
    logic [31:0] p_req, vehicle_max_power, p_min, p_max;
    assign i_req = regs_reg[1][15:0];
    assign v_req = regs_reg[2][15:0];
    assign p_req = regs_reg[3];
    assign vehicle_max_current = regs_reg[4][15:0];
    assign vehicle_max_battery_voltage = regs_reg[5][15:0];
    assign vehicle_max_power = regs_reg[6];
    assign i_min = regs_reg[7][15:0];
    assign i_max = regs_reg[8][15:0];
    assign v_min = regs_reg[9][15:0];
    assign v_max = regs_reg[10][15:0];
    assign p_min = regs_reg[11];
    assign p_max = regs_reg[12];

    // One wait state: PREADY rises in the second access cycle
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            prdata_reg <= RST_ZERO;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= PSEL && PENABLE && !pready_reg;
            prdata_reg <= (PSEL && PENABLE && !pready_reg && !PWRITE) ? rd_mux : RST_ZERO;
            pslverr_reg <= PSEL && PENABLE && !pready_reg && !mapped;
        end
    end

    // Request and limit words
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 1; k <= 12; k++) begin
                regs_reg[k] <= RST_ZERO;
            end
        end else if (wr && PADDR >= OFS_VEH_I_REQ && PADDR <= OFS_STA_P_MAX) begin
            regs_reg[PADDR[5:2]] <= PWDATA;
        end
    end

    // Run bit and mask; a stop drops run
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= 1'b0;
            mask_reg <= '0;
        end else begin
            if (ERROR_STOP || EMERG_STOP) begin
                run_reg <= 1'b0;
            end else if (wr && PADDR == OFS_CTRL) begin
                run_reg <= PWDATA[CTRL_RUN];
            end
            if (wr && PADDR == OFS_MASK) begin
                mask_reg <= PWDATA[ST_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Measurements and target computation
    // ------------------------------------------------------------
    logic [15:0] meas_v_reg, meas_i_reg; // Latest samples
    logic [TMR_W-1:0] age_reg; // Sample age in ms
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            meas_v_reg <= '0;
            meas_i_reg <= '0;
            age_reg <= '1;
        end else if (meas_new) begin
            meas_v_reg <= meas_s2_reg[31:16];
            meas_i_reg <= meas_s2_reg[15:0];
            age_reg <= '0;
        end else if (tick_reg && age_reg != '1) begin
            age_reg <= age_reg + 1'b1;
        end
    end

    logic [15:0] i_lim, v_lim, v_low;
    logic [31:0] p_vi, p_cap, p_ask;
    logic minp_exp, ov_exp, uv_exp, oc_exp, oc_cond, uv_cond;
    logic zc_station, zc_now;
    assign i_lim = (vehicle_max_current < i_max) ? vehicle_max_current : i_max;
    assign v_lim = (v_req < v_max) ? v_req : v_max;
    assign v_low = (meas_v_reg < v_req) ? meas_v_reg : v_req;
    assign p_vi = meas_v_reg * i_req;
    assign p_cap = (vehicle_max_power < p_max) ? vehicle_max_power : p_max;
    assign p_ask = (p_vi < p_req) ? p_vi : p_req;
    // Station unable to deliver
    assign zc_station = (i_max == 16'h0000) || (p_max == RST_ZERO);
    assign zc_now = (i_req == 16'h0000) || zc_station
        || (i_req < i_min)
        || (p_req < p_min)
        || minp_exp;

    // Registered targets; capped power request goes out as the limit
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            I_TARGET <= '0;
            V_TARGET <= '0;
            P_LIMIT <= RST_ZERO;
            ZERO_CURRENT <= 1'b1;
        end else begin
            ZERO_CURRENT <= zc_now || !run_reg;
            if (zc_now || !run_reg) begin
                I_TARGET <= 16'h0000;
            end else begin
                I_TARGET <= (i_req > i_lim) ? i_lim : i_req;
            end
            V_TARGET <= run_reg ? v_lim : 16'h0000;
            P_LIMIT <= (p_ask > p_cap) ? p_cap : p_ask;
        end
    end

    // ------------------------------------------------------------
    // Protection timers
    // ------------------------------------------------------------
    // Products widened so the scaled comparisons cannot wrap
    logic [18:0] oc_lhs, oc_rhs, uv_lhs, uv_rhs;
    assign oc_lhs = meas_i_reg * OC_DEN;
    assign oc_rhs = i_max * OC_NUM;
    assign uv_lhs = meas_v_reg * UV_DEN;
    assign uv_rhs = v_min * UV_NUM;
    assign oc_cond = oc_lhs > oc_rhs;
    assign uv_cond = run_reg && (uv_lhs < uv_rhs);

    dcls_persist #(.LIMIT_MS(OV_PERSIST_MS)) u_ov (
        .clk(REF_CLK), .rst_n(rst_n), .tick(tick_reg),
        .cond(run_reg && meas_v_reg >= v_max), .expired(ov_exp)
    );
    dcls_persist #(.LIMIT_MS(UV_PERSIST_MS)) u_uv (
        .clk(REF_CLK), .rst_n(rst_n), .tick(tick_reg),
        .cond(run_reg && v_low < v_min), .expired(uv_exp)
    );
    dcls_persist #(.LIMIT_MS(MINP_PERSIST_MS)) u_minp (
        .clk(REF_CLK), .rst_n(rst_n), .tick(tick_reg),
        .cond(run_reg && p_vi < p_min), .expired(minp_exp)
    );
    dcls_persist #(.LIMIT_MS(OC_PERSIST_MS)) u_oc (
        .clk(REF_CLK), .rst_n(rst_n), .tick(tick_reg),
        .cond(oc_cond || uv_cond), .expired(oc_exp)
    );

    // Stops latch until software restarts the session
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ERROR_STOP <= 1'b0;
            EMERG_STOP <= 1'b0;
        end else begin
            if (ov_exp || uv_exp) begin
                ERROR_STOP <= 1'b1;
            end else if (wr && PADDR == OFS_CTRL && PWDATA[CTRL_RUN]) begin
                ERROR_STOP <= 1'b0;
            end
            if (oc_exp) begin
                EMERG_STOP <= 1'b1;
            end else if (wr && PADDR == OFS_CTRL && PWDATA[CTRL_RUN]) begin
                EMERG_STOP <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outgoing message snapshot
    // ------------------------------------------------------------
    logic send_pend_reg; // Waiting for a fresh sample
    logic lim_chg_reg; // Limit changed since last message
    logic zc_station_d_reg;
    logic snap; // Snapshot taken this cycle
    logic [15:0] msg_v_reg, msg_i_reg, msg_imax_reg;
    logic [31:0] msg_pmax_reg;
    logic msg_chg_reg;
    logic send_req;
    logic stale;
    assign send_req = wr && PADDR == OFS_MSG_CMD && PWDATA[0];
    assign stale = age_reg >= TMR_W'(MEAS_MAX_AGE_MS);
    assign snap = (send_req || send_pend_reg) && !stale;
    logic lim_write;
    assign lim_write = wr && ((PADDR == OFS_STA_I_MAX && PWDATA[15:0] != i_max)
        || (PADDR == OFS_STA_P_MAX && PWDATA != p_max));

    // Stale samples held back; ask for a new one
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            send_pend_reg <= 1'b0;
            REMEASURE_REQ <= 1'b0;
        end else begin
            send_pend_reg <= (send_req || send_pend_reg) && stale;
            REMEASURE_REQ <= (send_req || send_pend_reg) && stale;
        end
    end

    // Change flag: a new change in the snapshot cycle wins
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            lim_chg_reg <= 1'b0;
            zc_station_d_reg <= 1'b0;
        end else begin
            zc_station_d_reg <= zc_station;
            if (lim_write || zc_station != zc_station_d_reg) begin
                lim_chg_reg <= 1'b1;
            end else if (snap) begin
                lim_chg_reg <= 1'b0;
            end
        end
    end

    // Snapshot the message words
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            msg_v_reg <= '0;
            msg_i_reg <= '0;
            msg_imax_reg <= '0;
            msg_pmax_reg <= RST_ZERO;
            msg_chg_reg <= 1'b0;
        end else if (snap) begin
            msg_v_reg <= meas_v_reg;
            msg_i_reg <= meas_i_reg;
            msg_imax_reg <= zc_station ? 16'h0000 : i_max;
            msg_pmax_reg <= p_max;
            msg_chg_reg <= lim_chg_reg || lim_write;
        end
    end

    // ------------------------------------------------------------
    // Status, interrupt and read mux
    // ------------------------------------------------------------
    logic [ST_W-1:0] ev;
    logic zc_d_reg;
    assign ev = {snap, ZERO_CURRENT && !zc_d_reg, oc_exp, uv_exp, ov_exp};
    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sts_reg <= '0;
            zc_d_reg <= 1'b1;
            IRQ <= 1'b0;
        end else begin
            zc_d_reg <= ZERO_CURRENT;
            if (wr && PADDR == OFS_STATUS) begin
                sts_reg <= (sts_reg & ~PWDATA[ST_W-1:0]) | ev;
            end else begin
                sts_reg <= sts_reg | ev;
            end
            IRQ <= |((sts_reg | ev) & mask_reg & ~((wr && PADDR == OFS_STATUS) ?
                PWDATA[ST_W-1:0] & ~ev : '0));
        end
    end

    // Readback; unmapped offsets give zero and an error
    always_comb begin
        mapped = 1'b1;
        rd_mux = RST_ZERO;
        case (PADDR)
            OFS_CTRL: rd_mux = {31'h0, run_reg};
            OFS_STATUS: rd_mux = {27'h0, sts_reg};
            OFS_MASK: rd_mux = {27'h0, mask_reg};
            OFS_TARGET: rd_mux = {V_TARGET, I_TARGET};
            OFS_MSG_CMD: rd_mux = {31'h0, send_pend_reg};
            OFS_MSG_V: rd_mux = {16'h0, msg_v_reg};
            OFS_MSG_I: rd_mux = {16'h0, msg_i_reg};
            OFS_MSG_IMAX: rd_mux = {16'h0, msg_imax_reg};
            OFS_MSG_PMAX: rd_mux = msg_pmax_reg;
            OFS_MSG_FLAGS: rd_mux = {31'h0, msg_chg_reg};
            OFS_PLIMIT: rd_mux = P_LIMIT;
            default: begin
                if (PADDR >= OFS_VEH_I_REQ && PADDR <= OFS_STA_P_MAX && PADDR[1:0] == 2'h0) begin
                    rd_mux = regs_reg[PADDR[5:2]];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    assign PREADY = pready_reg;
    assign PRDATA = prdata_reg;
    assign PSLVERR = pslverr_reg;
endmodule : dcls_top
`default_nettype wire

// ### tb_dc_charge_limit_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench top
// ----
module tb_dc_charge_limit_supervisor import dcls_pkg::*;;
    localparam int CMS = 2; // Short millisecond keeps run brief
    logic REF_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    wire [31:0] PRDATA, P_LIMIT;
    wire [15:0] MEAS_V, MEAS_I, I_TARGET, V_TARGET;
    wire PREADY, PSLVERR, MEAS_VALID, ZERO_CURRENT, ERROR_STOP, EMERG_STOP;
    wire REMEASURE_REQ, IRQ;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 32'h0007B83F;
    int ir, vr, pr, iv, im, imn, pmn, vmx, pvx, psx, ie, ve, pe;
    logic [31:0] rd;
    logic er, zc;
    dcls_top #(.CYC_MS(CMS)) u_dut (.REF_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .MEAS_V, .MEAS_I, .MEAS_VALID, .I_TARGET,
        .V_TARGET, .P_LIMIT, .ZERO_CURRENT, .ERROR_STOP, .EMERG_STOP, .REMEASURE_REQ, .IRQ);
    dcls_far_end u_far (.clk(REF_CLK), .meas_v(MEAS_V), .meas_i(MEAS_I), .meas_valid(MEAS_VALID));
    // 25 MHz clock and hang guard
    always #20 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            tally_and_finish();
        end
    end
    function automatic int mn(input int a, input int b);
        return (a < b) ? a : b;
    endfunction : mn
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Bus cycle: waits for ready; only the hang guard ends the wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input int d);
        apb(1'b1, a, 32'(d));
    endtask : wr
    task automatic wait_ms(input int m);
        repeat (m * CMS) @(posedge REF_CLK);
        #1;
    endtask : wait_ms
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (4) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        for (int a = 4; a <= 8'h30; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk("reset", 32'h0, rd);
        end
        apb(1'b0, 8'h5C, 32'h0);
        chk("slverr", 32'h1, 32'(er));
        chk("unmapped", 32'h0, rd);
        $display("test regs done");
        wr(OFS_CTRL, 1);
        u_far.send(16'd1000, 16'h0);
        for (int k = 0; k < 10; k++) begin
            ir = $random(seed) & 32'h3FF;
            imn = $random(seed) & 32'hFF;
            iv = $random(seed) & 32'h3FF;
            im = $random(seed) & 32'h3FF;
            vr = $random(seed) & 32'hFFF;
            vmx = 2000 + ($random(seed) & 32'h7FF);
            pr = $random(seed) & 32'hFFFFF;
            pmn = $random(seed) & 32'h3FFFF;
            pvx = $random(seed) & 32'hFFFFF;
            psx = $random(seed) & 32'hFFFFF;
            wr(OFS_VEH_I_REQ, ir);
            wr(OFS_STA_I_MIN, imn);
            wr(OFS_VEH_I_MAX, iv);
            wr(OFS_STA_I_MAX, im);
            wr(OFS_VEH_V_REQ, vr);
            wr(OFS_VEH_V_MAX, vr / 2);
            wr(OFS_STA_V_MAX, vmx);
            wr(OFS_VEH_P_REQ, pr);
            wr(OFS_STA_P_MIN, pmn);
            wr(OFS_VEH_P_MAX, pvx);
            wr(OFS_STA_P_MAX, psx);
            zc = ir == 0 || ir < imn || pr < pmn || im == 0 || psx == 0;
            ie = zc ? 0 : mn(ir, mn(iv, im));
            ve = mn(vr, vmx);
            pe = mn(mn(1000 * ir, pr), mn(pvx, psx));
            wait_ms(2);
            chk("itarget", 32'(ie), 32'(I_TARGET));
            chk("vtarget", 32'(ve), 32'(V_TARGET));
            chk("zero", 32'(zc), 32'(ZERO_CURRENT));
            chk("plimit", 32'(pe), P_LIMIT);
            apb(1'b0, OFS_TARGET, 32'h0);
            chk("target", {16'(ve), 16'(ie)}, rd);
        end
        $display("test targets done");
        wr(OFS_STA_V_MAX, 2000);
        wr(OFS_STATUS, 32'h1F);
        wr(OFS_MASK, 0);
        u_far.send(16'd2000, 16'h0);
        wait_ms(300);
        u_far.send(16'd1000, 16'h0);
        u_far.send(16'd2000, 16'h0);
        wait_ms(395);
        chk("ov early", 32'h0, 32'(ERROR_STOP));
        wait_ms(17);
        chk("ov stop", 32'h1, 32'(ERROR_STOP));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("ov status", 32'h1, 32'(rd[ST_OV]));
        chk("irq masked", 32'h0, 32'(IRQ));
        wr(OFS_MASK, 1 << ST_OV);
        wait_ms(2);
        chk("irq set", 32'h1, 32'(IRQ));
        wr(OFS_STATUS, 1 << ST_OV);
        wait_ms(2);
        chk("irq clear", 32'h0, 32'(IRQ));
        u_far.send(16'd1000, 16'h0);
        wr(OFS_CTRL, 1);
        wait_ms(1);
        chk("ov cleared", 32'h0, 32'(ERROR_STOP));
        $display("test overvoltage done");
        wr(OFS_STA_I_MAX, 100);
        u_far.send(16'd1000, 16'd120);
        wait_ms(300);
        u_far.send(16'd1000, 16'd121);
        wait_ms(480);
        chk("oc early", 32'h0, 32'(EMERG_STOP));
        wait_ms(40);
        chk("oc stop", 32'h1, 32'(EMERG_STOP));
        u_far.send(16'd1000, 16'h0);
        wr(OFS_CTRL, 1);
        wait_ms(1);
        chk("oc cleared", 32'h0, 32'(EMERG_STOP));
        $display("test overcurrent done");
        u_far.send(16'd1234, 16'd56);
        wait_ms(100);
        wr(OFS_MSG_CMD, 1);
        wait_ms(1);
        chk("fresh", 32'h0, 32'(REMEASURE_REQ));
        apb(1'b0, OFS_MSG_V, 32'h0);
        chk("msg v", 32'd1234, rd);
        wr(OFS_STA_P_MAX, 0);
        wait_ms(210);
        wr(OFS_MSG_CMD, 1);
        wait_ms(1);
        chk("stale", 32'h1, 32'(REMEASURE_REQ));
        u_far.send(16'd1300, 16'd60);
        wait_ms(2);
        chk("remeasured", 32'h0, 32'(REMEASURE_REQ));
        apb(1'b0, OFS_MSG_V, 32'h0);
        chk("msg new v", 32'd1300, rd);
        apb(1'b0, OFS_MSG_IMAX, 32'h0);
        chk("msg imax", 32'h0, rd);
        apb(1'b0, OFS_MSG_FLAGS, 32'h0);
        chk("msg flag", 32'h1, 32'(rd[0]));
        $display("test message done");
        tally_and_finish();
    end
endmodule : tb_dc_charge_limit_supervisor
`default_nettype wire
